// File: verilog/flash_ctl_defs.svh
// constants for the flash command controller
`ifndef FLASH_CTL_DEFS_SVH
`define FLASH_CTL_DEFS_SVH
// software register offsets
`define REG_CMD        4'h0
`define REG_ADDR       4'h1
`define REG_WDATA      4'h2
`define REG_RESULT     4'h3
`define REG_IRQ_STATUS 4'h4
`define REG_IRQ_CLEAR  4'h5
`define REG_IRQ_ENABLE 4'h6
`define REG_STATE      4'h7
// flash command codes
`define FC_READ_ARRAY  8'hff
`define FC_READ_STATUS 8'h70
`define FC_CLEAR_STAT  8'h50
`define FC_WRITE_SETUP 8'h40
`define FC_ERASE_SETUP 8'h20
`define FC_ERASE_CONF  8'hd0
// status register bit positions
`define SR_READY       7
`define SR_ERASE_ERR   5
`define SR_WRITE_ERR   4
`define SR_SUPPLY_LOW  3
`define SR_DEFINED     8'hf8
// software command field codes
`define OP_READ        3'h1
`define OP_WRITE       3'h2
`define OP_ERASE       3'h3
`define OP_CLEAR       3'h4
`define OP_SLEEP       3'h5
`define OP_WAKE        3'h6
// timing in ns, and strobe count reload in clocks, one less than the strobe length
`define CLK_NS         8
`define WAKE_READ_NS   400
`define WAKE_WRITE_NS  1000
`define STROBE_CYC     4'h3
// interrupt bits
`define IRQ_DONE       0
`define IRQ_ERROR      1
`define IRQ_SUPPLY     2
`endif

// File: verilog/flash_ctl_pkg.sv
// types shared by the flash command controller
package flash_ctl_pkg;
  typedef struct packed {
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic        rp_n;
    logic [19:0] addr;
  } flash_ctl_t;
  typedef enum logic [2:0] { BUS_IDLE, BUS_SETUP, BUS_STROBE, BUS_HOLD } bus_state_t;
  typedef enum logic [3:0] {
    ST_SLEEP, ST_WAKE, ST_IDLE, ST_CYC1, ST_CYC2, ST_POLL, ST_CHECK, ST_ARRAY, ST_READ, ST_CLEAR
  } seq_state_t;
endpackage

// File: verilog/flash_bus_cycle.sv
// one asynchronous bus cycle on the flash pins
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_defs.svh"
module flash_bus_cycle (
  input  wire logic       clk_sys,   // system clock
  input  wire logic       srst,      // sync reset
  input  wire logic       ce,        // clock enable
  input  wire logic       start,     // begin a cycle
  input  wire logic       is_write,  // 1 write, 0 read
  input  wire logic [7:0] wdata,     // data to drive
  input  wire logic [7:0] dq_in,     // data pins in
  output logic            busy,      // cycle in progress
  output logic            done,      // one-cycle finish pulse
  output logic [7:0]      rdata,     // captured read data
  output logic            ce_n,      // chip select
  output logic            we_n,      // write strobe
  output logic            oe_n,      // output enable
  output logic [7:0]      dq_out,    // data pins out
  output logic            dq_oe      // drive data pins
);
  flash_ctl_pkg::bus_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] next_rdata;
  logic       wr, next_wr;
  // both select and strobe go low together only in the strobe phase
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_rdata = rdata;
    next_wr    = wr;
    case (state)
      flash_ctl_pkg::BUS_IDLE: if (start) begin
        next_wr    = is_write;
        next_state = flash_ctl_pkg::BUS_SETUP;
      end
      flash_ctl_pkg::BUS_SETUP: begin
        next_cnt   = `STROBE_CYC;
        next_state = flash_ctl_pkg::BUS_STROBE;
      end
      flash_ctl_pkg::BUS_STROBE: if (cnt == 4'h0) begin
        next_rdata = dq_in;
        next_state = flash_ctl_pkg::BUS_HOLD;
      end else begin
        next_cnt = cnt - 4'h1;
      end
      flash_ctl_pkg::BUS_HOLD: next_state = flash_ctl_pkg::BUS_IDLE;
      default: next_state = flash_ctl_pkg::BUS_IDLE;
    endcase
  end
  // pins are registered; data held through hold for write hold margin
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= flash_ctl_pkg::BUS_IDLE;
      cnt <= 4'h0;
      rdata <= 8'h00;
      wr <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      dq_out <= 8'h00;
      dq_oe <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
      rdata <= next_rdata;
      wr <= next_wr;
      busy <= next_state != flash_ctl_pkg::BUS_IDLE;
      done <= state == flash_ctl_pkg::BUS_HOLD;
      ce_n <= next_state != flash_ctl_pkg::BUS_STROBE;
      we_n <= !(next_state == flash_ctl_pkg::BUS_STROBE && next_wr);
      oe_n <= !(next_state == flash_ctl_pkg::BUS_STROBE && !next_wr);
      dq_out <= (state == flash_ctl_pkg::BUS_IDLE && start) ? wdata : dq_out;
      dq_oe <= next_state != flash_ctl_pkg::BUS_IDLE && next_wr;
    end
  end
endmodule
`default_nettype wire

// File: verilog/flash_ctl.sv
// host controller that drives a byte-wide flash through its pins
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_defs.svh"
module flash_ctl #(
  parameter int WAKE_READ_CYC  = (`WAKE_READ_NS + `CLK_NS - 1) / `CLK_NS,   // rounded up
  parameter int WAKE_WRITE_CYC = (`WAKE_WRITE_NS + `CLK_NS - 1) / `CLK_NS
) (
  input  wire logic       clk_sys,            // 125 MHz clock
  input  wire logic       srst,               // sync reset, active high
  input  wire logic       ce,                 // clock enable
  input  wire logic [3:0] addr,               // register address
  input  wire logic [31:0] wdata,             // register write data
  input  wire logic       wr,                 // write strobe
  input  wire logic       rd,                 // read strobe
  output logic [31:0]     rdata,              // read data, cycle after rd
  output logic            irq,                // level interrupt
  output logic [19:0]     flash_addr,         // flash address pins
  output logic            chip_select_n,      // flash chip select
  output logic            write_strobe_n,     // flash write strobe
  output logic            output_enable_n,    // flash output enable
  output logic            power_down_reset_n, // flash reset/power-down
  output logic [7:0]      dq_out,             // data pins out
  output logic            dq_oe,              // drive data pins
  input  wire logic [7:0] dq_in,              // data pins in
  input  wire logic       ready_busy_n        // flash ready/busy
);
  // ************************************************************
  // sequencer state
  // ************************************************************
  flash_ctl_pkg::seq_state_t state, next_state;
  flash_ctl_pkg::flash_ctl_t pins;
  logic [2:0]  op, next_op;
  logic [19:0] fa, next_fa;
  logic [7:0]  wd, next_wd;
  logic [7:0]  result, next_result;
  logic [15:0] wake_cnt, next_wake_cnt;
  logic        rp, next_rp;
  logic        array_mode, next_array_mode;
  logic        sticky_low, next_sticky_low;
  logic [2:0]  ev;
  logic        bstart, bis_wr, bbusy, bdone, bce_n, bwe_n, boe_n, bdq_oe;
  logic [7:0]  bwd, brd, bdq;
  logic        go;

  // sleep must accept the wake op, its own branch drops every other op
  assign go = wr && addr == `REG_CMD && (state == flash_ctl_pkg::ST_IDLE || state == flash_ctl_pkg::ST_SLEEP);

  // ************************************************************
  // pin cycle engine
  // ************************************************************
  flash_bus_cycle u_cyc (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .ce       (ce),
    .start    (bstart),
    .is_write (bis_wr),
    .wdata    (bwd),
    .dq_in    (dq_in),
    .busy     (bbusy),
    .done     (bdone),
    .rdata    (brd),
    .ce_n     (bce_n),
    .we_n     (bwe_n),
    .oe_n     (boe_n),
    .dq_out   (bdq),
    .dq_oe    (bdq_oe)
  );

  // sequencing: every flash command is a pin cycle started from here
  always_comb begin
    next_state = state;
    next_op = op;
    next_fa = fa;
    next_wd = wd;
    next_result = result;
    next_wake_cnt = (wake_cnt != 16'h0) ? wake_cnt - 16'h1 : wake_cnt;
    next_rp = rp;
    next_array_mode = array_mode;
    next_sticky_low = sticky_low;
    bstart = 1'b0;
    bis_wr = 1'b1;
    bwd = `FC_READ_STATUS;
    ev = 3'h0;
    case (state)
      flash_ctl_pkg::ST_SLEEP: if (go && wdata[2:0] == `OP_WAKE) begin
        next_rp = 1'b1;
        // the longer wake delay covers both reads and strobes
        next_wake_cnt = 16'(WAKE_WRITE_CYC > WAKE_READ_CYC ? WAKE_WRITE_CYC : WAKE_READ_CYC);
        next_state = flash_ctl_pkg::ST_WAKE;
      end
      flash_ctl_pkg::ST_WAKE: if (wake_cnt == 16'h0) begin
        next_array_mode = 1'b1; // device wakes in read-array mode
        ev[`IRQ_DONE] = 1'b1;
        next_state = flash_ctl_pkg::ST_IDLE;
      end
      flash_ctl_pkg::ST_IDLE: if (go) begin
        next_op = wdata[2:0];
        next_fa = wdata[27:8];
        next_wd = wdata[7:0];
        case (wdata[2:0])
          `OP_SLEEP: begin
            next_rp = 1'b0; // flash ignores everything else meanwhile
            ev[`IRQ_DONE] = 1'b1;
            next_state = flash_ctl_pkg::ST_SLEEP;
          end
          `OP_WRITE, `OP_ERASE: begin
            if (sticky_low) begin
              ev[`IRQ_SUPPLY] = 1'b1; // refused until cleared
            end else begin
              next_state = flash_ctl_pkg::ST_CYC1;
            end
          end
          `OP_READ: next_state = array_mode ? flash_ctl_pkg::ST_READ : flash_ctl_pkg::ST_ARRAY;
          `OP_CLEAR: next_state = flash_ctl_pkg::ST_CLEAR;
          default: ev[`IRQ_ERROR] = 1'b1;
        endcase
      end
      flash_ctl_pkg::ST_CYC1: begin
        // setup then confirm: a single cycle alone never alters the array
        bstart = !bbusy && !bdone; // the finish cycle must not relaunch the setup
        bwd = (op == `OP_WRITE) ? `FC_WRITE_SETUP : `FC_ERASE_SETUP;
        next_array_mode = 1'b0;
        if (bdone) next_state = flash_ctl_pkg::ST_CYC2;
      end
      flash_ctl_pkg::ST_CYC2: begin
        bstart = !bbusy && !bdone;
        bwd = (op == `OP_WRITE) ? wd : `FC_ERASE_CONF;
        if (bdone) next_state = flash_ctl_pkg::ST_POLL;
      end
      flash_ctl_pkg::ST_POLL: if (ready_busy_n && !bbusy) begin // completion first
        bstart = 1'b1;
        bis_wr = 1'b0;
        next_state = flash_ctl_pkg::ST_CHECK;
      end
      flash_ctl_pkg::ST_CHECK: if (bdone) begin
        next_result = brd & `SR_DEFINED;
        if (!brd[`SR_READY]) begin
          next_state = flash_ctl_pkg::ST_POLL;
        end else begin
          ev[`IRQ_DONE] = 1'b1;
          ev[`IRQ_ERROR] = brd[`SR_WRITE_ERR] | brd[`SR_ERASE_ERR];
          ev[`IRQ_SUPPLY] = brd[`SR_SUPPLY_LOW];
          next_sticky_low = sticky_low | brd[`SR_SUPPLY_LOW];
          next_state = flash_ctl_pkg::ST_IDLE;
        end
      end
      flash_ctl_pkg::ST_ARRAY: begin
        bstart = !bbusy && !bdone;
        bwd = `FC_READ_ARRAY;
        if (bdone) begin
          next_array_mode = 1'b1;
          next_state = flash_ctl_pkg::ST_READ;
        end
      end
      flash_ctl_pkg::ST_READ: begin
        bstart = !bbusy && !bdone;
        bis_wr = 1'b0;
        if (bdone) begin
          next_result = brd;
          ev[`IRQ_DONE] = 1'b1;
          next_state = flash_ctl_pkg::ST_IDLE;
        end
      end
      flash_ctl_pkg::ST_CLEAR: begin
        bstart = !bbusy && !bdone;
        bwd = `FC_CLEAR_STAT;
        next_array_mode = 1'b0;
        if (bdone) begin
          next_sticky_low = 1'b0;
          ev[`IRQ_DONE] = 1'b1;
          next_state = flash_ctl_pkg::ST_IDLE;
        end
      end
      default: next_state = flash_ctl_pkg::ST_IDLE;
    endcase
  end

  // ************************************************************
  // interrupt and register file
  // ************************************************************
  logic [2:0]  irq_status, next_irq_status, irq_enable, next_irq_enable;
  logic [31:0] next_rdata;
  logic        busy_flag;
  assign busy_flag = state != flash_ctl_pkg::ST_IDLE && state != flash_ctl_pkg::ST_SLEEP;
  // a new event wins over a same-cycle clear
  always_comb begin
    next_irq_status = irq_status;
    next_irq_enable = irq_enable;
    next_rdata = 32'h0;
    if (wr && addr == `REG_IRQ_CLEAR) next_irq_status = irq_status & ~wdata[2:0];
    next_irq_status = next_irq_status | ev;
    if (wr && addr == `REG_IRQ_ENABLE) next_irq_enable = wdata[2:0];
    if (rd) begin
      case (addr)
        `REG_RESULT:     next_rdata = {24'h0, result};
        `REG_IRQ_STATUS: next_rdata = {29'h0, irq_status};
        `REG_IRQ_ENABLE: next_rdata = {29'h0, irq_enable};
        `REG_STATE:      next_rdata = {26'h0, ready_busy_n, sticky_low, array_mode, rp, busy_flag, 1'b0};
        default:         next_rdata = 32'h0;
      endcase
    end
  end

  always_comb begin
    pins.ce_n = bce_n; // chip select and strobe low only together
    pins.we_n = bwe_n;
    pins.oe_n = boe_n;
    pins.rp_n = rp;
    pins.addr = fa;
  end

  // reset leaves the flash in power-down until software wakes it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= flash_ctl_pkg::ST_SLEEP;
      op <= 3'h0;
      fa <= 20'h0;
      wd <= 8'h00;
      result <= 8'h00;
      wake_cnt <= 16'h0;
      rp <= 1'b0;
      array_mode <= 1'b0;
      sticky_low <= 1'b0;
      irq_status <= 3'h0;
      irq_enable <= 3'h0;
      rdata <= 32'h0;
      irq <= 1'b0;
      flash_addr <= 20'h0;
      chip_select_n <= 1'b1;
      write_strobe_n <= 1'b1;
      output_enable_n <= 1'b1;
      power_down_reset_n <= 1'b0; // a cut write or erase is not resumed, software reissues it
      dq_out <= 8'h00;
      dq_oe <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      op <= next_op;
      fa <= next_fa;
      wd <= next_wd;
      result <= next_result;
      wake_cnt <= next_wake_cnt;
      rp <= next_rp;
      array_mode <= next_array_mode;
      sticky_low <= next_sticky_low;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      rdata <= next_rdata;
      irq <= |(next_irq_status & next_irq_enable);
      flash_addr <= pins.addr;
      chip_select_n <= pins.ce_n;
      write_strobe_n <= pins.we_n;
      output_enable_n <= pins.oe_n;
      power_down_reset_n <= pins.rp_n;
      dq_out <= bdq;
      dq_oe <= bdq_oe;
    end
  end
endmodule
`default_nettype wire

// File: verification/flash_ctl_monitor.sv
// checker on the pins and register port of the flash controller
`timescale 1ns/10ps
`default_nettype none
module flash_ctl_monitor #(
  parameter int WAKE_READ_CYC  = 2,
  parameter int WAKE_WRITE_CYC = 2
) (
  input wire logic        clk_sys,            // clock
  input wire logic        srst,               // reset
  input wire logic        rd,                 // read strobe
  input wire logic [31:0] rdata,              // read data
  input wire logic        irq,                // interrupt
  input wire logic        chip_select_n,      // select
  input wire logic        write_strobe_n,     // write strobe
  input wire logic        output_enable_n,    // output enable
  input wire logic        power_down_reset_n, // power-down
  input wire logic [7:0]  dq_out,             // data out
  input wire logic        dq_oe               // data drive
);
  // ****************************************
  // cycles since wake, saturating so long idle stays legal
  // ****************************************
  logic [7:0] awake;
  logic [7:0] next_awake;
  always_comb begin
    next_awake = awake;
    if (srst || !power_down_reset_n) next_awake = 8'h00;
    else if (awake != 8'hff) next_awake = awake + 8'h01;
  end
  always_ff @(posedge clk_sys) begin
    awake <= next_awake;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence setup_sent;
    $rose(write_strobe_n) && dq_out == 8'h40;
  endsequence
  sequence second_sent;
    ##[1:64] $rose(write_strobe_n);
  endsequence
  a_sleep_quiet: assert property (
    !power_down_reset_n |-> chip_select_n && write_strobe_n && !dq_oe) else $error("pins active in power-down");
  a_write_select: assert property (
    !write_strobe_n |-> !chip_select_n) else $error("write strobe without select");
  a_no_contention: assert property (
    !output_enable_n |-> !dq_oe) else $error("data driven during read");
  a_wake_write: assert property (
    !write_strobe_n |-> awake >= WAKE_WRITE_CYC) else $error("write too soon after wake");
  a_wake_read: assert property (
    !output_enable_n |-> awake >= WAKE_READ_CYC) else $error("read too soon after wake");
  a_setup_pair: assert property (
    setup_sent |-> second_sent) else $error("setup cycle left alone");
  a_data_at_latch: assert property (
    $rose(write_strobe_n) |-> $past(dq_oe)) else $error("data not driven at latch");
  a_rdata_quiet: assert property (
    !$past(rd) |-> rdata == 32'h0) else $error("read data outside its cycle");
  a_reset_state: assert property (disable iff (1'b0)
    $past(srst) |-> !irq && !power_down_reset_n) else $error("reset state wrong");
endmodule
bind flash_ctl flash_ctl_monitor #(.WAKE_READ_CYC(WAKE_READ_CYC), .WAKE_WRITE_CYC(WAKE_WRITE_CYC)) i_flash_ctl_monitor (
  .clk_sys(clk_sys), .srst(srst), .rd(rd), .rdata(rdata), .irq(irq), .chip_select_n(chip_select_n),
  .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
  .power_down_reset_n(power_down_reset_n), .dq_out(dq_out), .dq_oe(dq_oe));
`default_nettype wire

// File: verification/flash_dev_model.sv
// behavioural model of the byte-wide flash on the far side
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model #(
  parameter int BUSY_CYC = 20
) (
  input wire logic        clk_sys,            // sampling clock
  input wire logic [19:0] flash_addr,         // address
  input wire logic        chip_select_n,      // select
  input wire logic        write_strobe_n,     // write strobe
  input wire logic        output_enable_n,    // output enable
  input wire logic        power_down_reset_n, // power-down
  input wire logic [7:0]  dq_out,             // data from host
  input wire logic        supply_ok,          // programming supply good
  input wire logic        fail_next,          // make operations fail
  output logic [7:0]      dq_in,              // data to host
  output logic            ready_busy_n        // ready when high
);
  // ****************************************
  // state
  // ****************************************
  logic [7:0] mem [16];
  logic [7:0] sr = 8'h00;
  logic [7:0] cmd = 8'h00;
  logic [7:0] last = 8'h00;
  logic       got = 1'b0;
  logic       setup_wr = 1'b0;
  logic       setup_er = 1'b0;
  logic       show_sr = 1'b0;
  int         busy = 0;
  initial foreach (mem[i]) mem[i] = 8'hff;
  assign ready_busy_n = (busy == 0);
  // released lines show the inverse of the last value, never a stale copy
  assign dq_in = (power_down_reset_n && !chip_select_n && !output_enable_n) ?
                 (show_sr ? {busy == 0, sr[6:0]} : mem[flash_addr[3:0]]) : ~last;
  // command latch acts once the strobe is released
  always @(posedge clk_sys) begin
    if (!chip_select_n && !output_enable_n) last <= dq_in;
    if (!power_down_reset_n) begin
      sr <= 8'h00;
      show_sr <= 1'b0;
      setup_wr <= 1'b0;
      setup_er <= 1'b0;
      got <= 1'b0;
      busy <= (busy > 4) ? 4 : ((busy > 0) ? busy - 1 : 0);
    end else begin
      if (busy > 0) busy <= busy - 1;
      if (!chip_select_n && !write_strobe_n) begin
        cmd <= dq_out;
        got <= 1'b1;
      end else if (got) begin
        got <= 1'b0;
        if (setup_wr || setup_er) begin
          setup_wr <= 1'b0;
          setup_er <= 1'b0;
          busy <= BUSY_CYC;
          if (sr[3]) busy <= 0;
          else if (!supply_ok) sr <= sr | 8'h08 | (setup_wr ? 8'h10 : 8'h20);
          else if (fail_next || (setup_er && cmd != 8'hd0)) sr <= sr | (setup_wr ? 8'h10 : 8'h20);
          else if (setup_wr) mem[flash_addr[3:0]] <= mem[flash_addr[3:0]] & cmd;
          else foreach (mem[i]) mem[i] <= 8'hff;
        end else case (cmd)
          8'hff: show_sr <= 1'b0;
          8'h70: show_sr <= 1'b1;
          8'h50: sr <= 8'h00;
          8'h40: setup_wr <= 1'b1;
          8'h20: setup_er <= 1'b1;
          default: ;
        endcase
        if (cmd == 8'h40 || cmd == 8'h20) show_sr <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/flash_ctl_test.sv
// testbench for the flash command controller
`timescale 1ns/10ps
`default_nettype none
module flash_ctl_test;
  logic        clk_sys, srst, ce, wr, rd, irq, supply_ok, fail_next, dq_oe, ready_busy_n;
  logic        chip_select_n, write_strobe_n, output_enable_n, power_down_reset_n;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, v;
  logic [19:0] flash_addr;
  logic [7:0]  dq_out, dq_in;
  int          failures, comparisons, cycles, strobes, s0;
  flash_ctl #(.WAKE_READ_CYC(2), .WAKE_WRITE_CYC(2)) i_flash_ctl (.clk_sys(clk_sys), .srst(srst), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .flash_addr(flash_addr),
    .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
    .power_down_reset_n(power_down_reset_n), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
    .ready_busy_n(ready_busy_n));
  flash_dev_model i_flash_dev_model (.clk_sys(clk_sys), .flash_addr(flash_addr), .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n), .power_down_reset_n(power_down_reset_n),
    .dq_out(dq_out), .supply_ok(supply_ok), .fail_next(fail_next), .dq_in(dq_in), .ready_busy_n(ready_busy_n));
  // ****************************************
  // clock, watchdog and helpers
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // counting strobes shows flash cycles that must not happen
  always @(negedge write_strobe_n) strobes++;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // issue a command, wait for the interrupt, check and clear its cause
  task automatic run(input logic [31:0] w, input logic [31:0] mask, input logic [31:0] exp);
    int n;
    wr_reg(4'h0, w);
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 2000) begin
      failures++;
      report_and_stop();
    end
    rd_reg(4'h4);
    check(v & mask, exp);
    wr_reg(4'h5, 32'h7);
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {srst, ce, wr, rd, addr, wdata, supply_ok, fail_next} = {1'b1, 1'b1, 38'h0, 1'b1, 1'b0};
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    rd_reg(4'h1);
    check(v, 32'h0);
    rd_reg(4'h7);
    check(v & 32'h4, 32'h0);
    wr_reg(4'h6, 32'h0);
    wr_reg(4'h0, 32'h6);
    repeat (300) @(posedge clk_sys);
    check({31'h0, irq}, 32'h0);
    rd_reg(4'h4);
    check(v & 32'h1, 32'h1);
    wr_reg(4'h6, 32'h7);
    repeat (3) @(posedge clk_sys);
    check({31'h0, irq}, 32'h1);
    wr_reg(4'h5, 32'h7);
    repeat (3) @(posedge clk_sys);
    check({31'h0, irq}, 32'h0);
    rd_reg(4'h7);
    check(v & 32'hc, 32'hc);
    $display("test wake_and_irq done");
    run(32'h000005a2, 32'h1, 32'h1);
    rd_reg(4'h3);
    check(v & 32'hff, 32'h80);
    run(32'h00000501, 32'h1, 32'h1);
    rd_reg(4'h3);
    check(v & 32'hff, 32'ha2);
    $display("test write_read done");
    fail_next <= 1'b1;
    run(32'h00000003, 32'h3, 32'h3);
    rd_reg(4'h3);
    check(v & 32'hff, 32'ha0);
    run(32'h000005a2, 32'h3, 32'h3);
    rd_reg(4'h3);
    check(v & 32'hff, 32'hb0);
    fail_next <= 1'b0;
    supply_ok <= 1'b0;
    run(32'h000005a2, 32'h7, 32'h7);
    rd_reg(4'h3);
    check(v & 32'hff, 32'hb8);
    supply_ok <= 1'b1;
    s0 = strobes;
    run(32'h000005a2, 32'h4, 32'h4);
    check(strobes, s0);
    rd_reg(4'h7);
    check(v & 32'h10, 32'h10);
    run(32'h00000004, 32'h1, 32'h1);
    rd_reg(4'h7);
    check(v & 32'h10, 32'h0);
    run(32'h00000003, 32'h3, 32'h1);
    rd_reg(4'h3);
    check(v & 32'hff, 32'h80);
    run(32'h00000501, 32'h1, 32'h1);
    rd_reg(4'h3);
    check(v & 32'hff, 32'hff);
    $display("test errors_and_supply done");
    fail_next <= 1'b1;
    run(32'h000005a2, 32'h3, 32'h3);
    fail_next <= 1'b0;
    run(32'h00000005, 32'h1, 32'h1);
    rd_reg(4'h7);
    check(v & 32'h4, 32'h0);
    run(32'h00000006, 32'h1, 32'h1);
    run(32'h000005a2, 32'h3, 32'h1);
    rd_reg(4'h3);
    check(v & 32'hff, 32'h80);
    $display("test sleep_wake done");
    // reset in mid-write: the flash stays busy, the write is reissued whole
    wr_reg(4'h0, 32'h000007c2);
    repeat (20) @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd_reg(4'h7);
    check(v & 32'h24, 32'h0);
    wr_reg(4'h6, 32'h7);
    run(32'h00000006, 32'h1, 32'h1);
    run(32'h000007c2, 32'h3, 32'h1);
    run(32'h00000701, 32'h1, 32'h1);
    rd_reg(4'h3);
    check(v & 32'hff, 32'hc2);
    $display("test reset_reissue done");
    report_and_stop();
  end
endmodule
`default_nettype wire
